/* File: design/crypto_command_control.sv */
/*
  crypto command control: avalon-mm slave holding the operation_select and
  engine_activity_flags registers, an fsm that decodes op codes and drives
  the cipher core, fingerprint engine and random source mux.
  assumes engines answer with a one-cycle done pulse and hold their outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module crypto_command_control
  import cmd_ctrl_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // avalon-mm slave
  input wire logic [1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // block data ports
  input wire logic [cmd_ctrl_pkg::BLOCK_W-1:0] DATA_IN,
  output logic [cmd_ctrl_pkg::BLOCK_W-1:0] DATA_OUT,
  // cipher core
  output logic [3:0] CIPHER_CMD,
  output logic CIPHER_START,
  input wire logic CIPHER_DONE,
  input wire logic [cmd_ctrl_pkg::BLOCK_W-1:0] CIPHER_RESULT,
  input wire logic CIPHER_TAG_OK,
  // fingerprint engine
  output logic FP_START,
  input wire logic FP_DONE,
  // random source
  output logic RANDOM_SOURCE_SELECT,
  input wire logic RANDOM_WORD_VALID
);
  import cmd_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CIPHER = 4'b0010,
    ST_FP = 4'b0100,
    ST_ACK = 4'b1000
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic [31:0] op;
    logic [8:0] flags;
    logic tag_ok;
    logic [3:0] ccmd;
    logic cstart;
    logic fstart;
    logic rnd_ready;
    logic [BLOCK_W-1:0] dout;
    logic [31:0] rdata;
    logic wait_n;
  } state_t;

  state_t cur_q, cur_d;
  logic [31:0] status_w;

  // bits 9 and up stay zero; the tag verdict is read at word 2 instead
  assign status_w = {23'h000000, RANDOM_SOURCE_SELECT, cur_q.rnd_ready,
                     cur_q.flags[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] map_cipher(input logic [31:0] op);
    case (op)
      OP_LOAD_KEY: map_cipher = CIPH_KEY;
      OP_LOAD_NONCE: map_cipher = CIPH_NONCE;
      OP_CIPHER_SETUP: map_cipher = CIPH_SETUP;
      OP_ABSORB_HEADER: map_cipher = CIPH_HEADER;
      OP_SEAL_BLOCK: map_cipher = CIPH_SEAL;
      OP_SEAL_LAST_BLOCK: map_cipher = CIPH_SEAL_LAST;
      OP_OPEN_BLOCK: map_cipher = CIPH_OPEN;
      OP_OPEN_LAST_BLOCK: map_cipher = CIPH_OPEN_LAST;
      OP_FETCH_TAG: map_cipher = CIPH_TAG;
      default: map_cipher = CIPH_NONE;
    endcase
  endfunction : map_cipher

  function automatic logic [6:0] phase_flag(input logic [3:0] c);
    phase_flag = 7'h00;
    case (c)
      CIPH_SETUP: phase_flag[FLAG_SETUP_ACTIVE] = 1'b1;
      CIPH_HEADER: phase_flag[FLAG_HEADER_ACTIVE] = 1'b1;
      CIPH_SEAL: phase_flag[FLAG_SEAL_ACTIVE] = 1'b1;
      CIPH_OPEN: phase_flag[FLAG_OPEN_ACTIVE] = 1'b1;
      CIPH_SEAL_LAST: phase_flag[FLAG_SEAL_LAST_ACTIVE] = 1'b1;
      CIPH_OPEN_LAST: phase_flag[FLAG_OPEN_LAST_ACTIVE] = 1'b1;
      default: phase_flag = 7'h00;
    endcase
  endfunction : phase_flag

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cur_d = cur_q;
    cur_d.cstart = 1'b0;
    cur_d.fstart = 1'b0;
    cur_d.wait_n = 1'b0;
    // fresh word sticky until read of status; new arrival wins over clear
    if (RANDOM_WORD_VALID)
    begin
      cur_d.rnd_ready = 1'b1;
    end
    unique case (cur_q.st)
      ST_IDLE:
      begin
        if (AVS_READ && !cur_q.wait_n)
        begin
          cur_d.wait_n = 1'b1;
          unique case (AVS_ADDRESS)
            ADDR_OPERATION_SELECT: cur_d.rdata = cur_q.op;
            ADDR_ENGINE_ACTIVITY:
            begin
              cur_d.rdata = status_w;
              if (!RANDOM_WORD_VALID)
              begin
                cur_d.rnd_ready = 1'b0;
              end
            end
            ADDR_DATA_IN_LO: cur_d.rdata = {31'h00000000, cur_q.tag_ok};
            ADDR_DATA_OUT_LO: cur_d.rdata = cur_q.dout[31:0];
            default: cur_d.rdata = READ_UNMAPPED;
          endcase
        end
        else if (AVS_WRITE && !cur_q.wait_n)
        begin
          cur_d.wait_n = 1'b1;
          if (AVS_ADDRESS == ADDR_OPERATION_SELECT)
          begin
            cur_d.op = AVS_WRITEDATA;
            if (AVS_WRITEDATA == OP_FINGERPRINT_RUN)
            begin
              cur_d.fstart = 1'b1;
              cur_d.flags[FLAG_FINGERPRINT_RUNNING] = 1'b1;
              cur_d.st = ST_FP;
              cur_d.wait_n = 1'b0;
            end
            else if (AVS_WRITEDATA == OP_RANDOM_RAW)
            begin
              cur_d.flags[FLAG_RANDOM_SOURCE_SELECT] = 1'b1;
            end
            else if (AVS_WRITEDATA == OP_RANDOM_DECIMATED)
            begin
              cur_d.flags[FLAG_RANDOM_SOURCE_SELECT] = 1'b0;
            end
            else if (map_cipher(AVS_WRITEDATA) != CIPH_NONE)
            begin
              cur_d.ccmd = map_cipher(AVS_WRITEDATA);
              cur_d.cstart = 1'b1;
              cur_d.flags[5:0] = 6'(phase_flag(map_cipher(AVS_WRITEDATA)));
              cur_d.st = ST_CIPHER;
              cur_d.wait_n = 1'b0;
            end
            // code 0 and unknown codes start nothing, status kept
          end
        end
      end
      ST_CIPHER:
      begin
        if (CIPHER_DONE)
        begin
          cur_d.flags[5:0] = 6'h00;
          if (cur_q.ccmd inside {CIPH_SEAL, CIPH_SEAL_LAST, CIPH_OPEN, CIPH_OPEN_LAST, CIPH_TAG})
          begin
            cur_d.dout = CIPHER_RESULT;
          end
          if (cur_q.ccmd == CIPH_OPEN_LAST)
          begin
            cur_d.tag_ok = CIPHER_TAG_OK;
          end
          cur_d.ccmd = CIPH_NONE;
          cur_d.st = ST_ACK;
        end
      end
      ST_FP:
      begin
        if (FP_DONE)
        begin
          cur_d.flags[FLAG_FINGERPRINT_RUNNING] = 1'b0;
          cur_d.st = ST_ACK;
        end
      end
      ST_ACK:
      begin
        cur_d.wait_n = 1'b1;
        cur_d.st = ST_IDLE;
      end
      default:
      begin
        cur_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cur_q <= '{st: ST_IDLE, op: OPERATION_RESET, ccmd: CIPH_NONE, default: '0};
    end
    else
    begin
      cur_q <= cur_d;
    end
  end

  assign AVS_READDATA = cur_q.rdata;
  assign AVS_WAITREQUEST = !cur_q.wait_n;
  assign DATA_OUT = cur_q.dout;
  assign CIPHER_CMD = cur_q.ccmd;
  assign CIPHER_START = cur_q.cstart;
  assign FP_START = cur_q.fstart;
  assign RANDOM_SOURCE_SELECT = cur_q.flags[FLAG_RANDOM_SOURCE_SELECT];

  ////////////////////////////////////////////////////////////////////////////
  chk_fp_flag_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_FP) |-> status_w[FLAG_FINGERPRINT_RUNNING])
    else $error("fingerprint busy flag dropped early");
  chk_fp_start_state: assert property (@(posedge MCLK) disable iff (SYS_RST)
    FP_START |-> (cur_q.st == ST_FP))
    else $error("fingerprint start outside run state");
  chk_fp_start_pulse: assert property (@(posedge MCLK) disable iff (SYS_RST)
    FP_START |=> !FP_START)
    else $error("fingerprint start longer than one cycle");
  chk_cstart_pulse: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CIPHER_START |=> !CIPHER_START)
    else $error("cipher start longer than one cycle");
  chk_cmd_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER && !CIPHER_DONE) |=> (CIPHER_CMD == $past(CIPHER_CMD)))
    else $error("cipher command changed while busy");
  chk_busy_wait: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER || cur_q.st == ST_FP) |-> AVS_WAITREQUEST)
    else $error("bus answered while an engine runs");
  chk_answer_once: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer stood longer than one cycle");
  chk_idle_code: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_IDLE && !cur_q.wait_n && AVS_WRITE && !AVS_READ
     && AVS_ADDRESS == ADDR_OPERATION_SELECT && AVS_WRITEDATA == OP_IDLE)
    |=> !CIPHER_START && !FP_START && cur_q.st == ST_IDLE)
    else $error("idle code started an engine");
  chk_seal_out: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER && CIPHER_DONE && cur_q.ccmd == CIPH_SEAL)
    |=> (DATA_OUT == $past(CIPHER_RESULT)))
    else $error("ciphertext block not presented");
  chk_load_no_out: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER && CIPHER_DONE && cur_q.ccmd == CIPH_KEY)
    |=> $stable(DATA_OUT))
    else $error("key load changed data out");
  chk_tag_verdict: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER && CIPHER_DONE && cur_q.ccmd == CIPH_OPEN_LAST)
    |=> (cur_q.tag_ok == $past(CIPHER_TAG_OK)))
    else $error("tag verdict not captured");
  chk_phase_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_CIPHER && CIPHER_DONE) |=> (status_w[5:0] == 6'h00))
    else $error("phase flag left set after done");
  chk_phase_seal: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (CIPHER_START && CIPHER_CMD == CIPH_SEAL) |-> status_w[FLAG_SEAL_ACTIVE])
    else $error("seal phase flag missing");
  chk_fp_flag_clear: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_FP && FP_DONE) |=> !status_w[FLAG_FINGERPRINT_RUNNING])
    else $error("fingerprint busy flag not cleared");
  chk_raw_select: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_IDLE && !cur_q.wait_n && AVS_WRITE && !AVS_READ
     && AVS_ADDRESS == ADDR_OPERATION_SELECT && AVS_WRITEDATA == OP_RANDOM_RAW)
    |=> RANDOM_SOURCE_SELECT)
    else $error("raw select not set");
  chk_dec_select: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_IDLE && !cur_q.wait_n && AVS_WRITE && !AVS_READ
     && AVS_ADDRESS == ADDR_OPERATION_SELECT && AVS_WRITEDATA == OP_RANDOM_DECIMATED)
    |=> !RANDOM_SOURCE_SELECT)
    else $error("decimated select not set");
  chk_mux_mirror: assert property (@(posedge MCLK) disable iff (SYS_RST)
    status_w[FLAG_RANDOM_SOURCE_SELECT] == RANDOM_SOURCE_SELECT)
    else $error("status bit 8 differs from mux select");
  chk_rnd_ready: assert property (@(posedge MCLK) disable iff (SYS_RST)
    RANDOM_WORD_VALID |=> status_w[FLAG_RANDOM_WORD_READY])
    else $error("random ready flag missing");
  chk_phase_one: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $onehot0(status_w[5:0]))
    else $error("more than one cipher phase flag");
  chk_cipher_start: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CIPHER_START |-> (CIPHER_CMD != CIPH_NONE) && cur_q.st == ST_CIPHER)
    else $error("cipher start without command");
  chk_upper_zero: assert property (@(posedge MCLK) disable iff (SYS_RST)
    status_w[31:9] == 23'h000000)
    else $error("unused status bits nonzero");
  chk_ack_idle: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (cur_q.st == ST_ACK) |=> (cur_q.st == ST_IDLE) && !AVS_WAITREQUEST)
    else $error("ack did not return to idle");
  cov_fp_run: cover property (@(posedge MCLK) disable iff (SYS_RST)
    FP_START ##[1:50] FP_DONE);
  cov_seal: cover property (@(posedge MCLK) disable iff (SYS_RST)
    CIPHER_START && CIPHER_CMD == CIPH_SEAL);
  cov_open_last: cover property (@(posedge MCLK) disable iff (SYS_RST)
    cur_q.st == ST_CIPHER && cur_q.ccmd == CIPH_OPEN_LAST && CIPHER_DONE);
  cov_rnd: cover property (@(posedge MCLK) disable iff (SYS_RST)
    RANDOM_WORD_VALID ##1 status_w[FLAG_RANDOM_WORD_READY]);
  cov_tag_fail: cover property (@(posedge MCLK) disable iff (SYS_RST)
    cur_q.st == ST_CIPHER && cur_q.ccmd == CIPH_OPEN_LAST && CIPHER_DONE && !CIPHER_TAG_OK);
endmodule : crypto_command_control
`default_nettype wire

/* File: include/cmd_ctrl_pkg.sv */
/*
  constants for the crypto command control block: register map, op codes,
  status bit positions, engine handshake widths.
  assumes a 32-bit avalon-mm slave with word addressing of four registers.
*/
package cmd_ctrl_pkg;
  localparam logic [1:0] ADDR_OPERATION_SELECT = 2'h0;
  localparam logic [1:0] ADDR_ENGINE_ACTIVITY = 2'h1;
  localparam logic [1:0] ADDR_DATA_IN_LO = 2'h2;
  localparam logic [1:0] ADDR_DATA_OUT_LO = 2'h3;
  localparam logic [31:0] OPERATION_RESET = 32'h00000000;
  localparam logic [31:0] OP_IDLE = 32'h00000000;
  localparam logic [31:0] OP_FINGERPRINT_RUN = 32'h00000001;
  localparam logic [31:0] OP_RANDOM_RAW = 32'h00000002;
  localparam logic [31:0] OP_RANDOM_DECIMATED = 32'h00000003;
  localparam logic [31:0] OP_LOAD_KEY = 32'h00000004;
  localparam logic [31:0] OP_LOAD_NONCE = 32'h00000005;
  localparam logic [31:0] OP_CIPHER_SETUP = 32'h00000006;
  localparam logic [31:0] OP_ABSORB_HEADER = 32'h00000007;
  localparam logic [31:0] OP_SEAL_BLOCK = 32'h00000008;
  localparam logic [31:0] OP_SEAL_LAST_BLOCK = 32'h00000009;
  localparam logic [31:0] OP_OPEN_BLOCK = 32'h0000000A;
  localparam logic [31:0] OP_OPEN_LAST_BLOCK = 32'h0000000B;
  localparam logic [31:0] OP_FETCH_TAG = 32'h0000000C;
  localparam int FLAG_SETUP_ACTIVE = 0;
  localparam int FLAG_HEADER_ACTIVE = 1;
  localparam int FLAG_SEAL_ACTIVE = 2;
  localparam int FLAG_OPEN_ACTIVE = 3;
  localparam int FLAG_SEAL_LAST_ACTIVE = 4;
  localparam int FLAG_OPEN_LAST_ACTIVE = 5;
  localparam int FLAG_FINGERPRINT_RUNNING = 6;
  localparam int FLAG_RANDOM_WORD_READY = 7;
  localparam int FLAG_RANDOM_SOURCE_SELECT = 8;
  localparam int FLAG_TAG_OK = 9;
  localparam int BLOCK_W = 128;
  localparam int STATE_W = 320;
  // cipher engine command encoding toward the core
  localparam logic [3:0] CIPH_NONE = 4'h0;
  localparam logic [3:0] CIPH_KEY = 4'h1;
  localparam logic [3:0] CIPH_NONCE = 4'h2;
  localparam logic [3:0] CIPH_SETUP = 4'h3;
  localparam logic [3:0] CIPH_HEADER = 4'h4;
  localparam logic [3:0] CIPH_SEAL = 4'h5;
  localparam logic [3:0] CIPH_SEAL_LAST = 4'h6;
  localparam logic [3:0] CIPH_OPEN = 4'h7;
  localparam logic [3:0] CIPH_OPEN_LAST = 4'h8;
  localparam logic [3:0] CIPH_TAG = 4'h9;
  localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage : cmd_ctrl_pkg

/* File: tb/test_crypto_command_control.sv */
/*
  self-checking bench for crypto_command_control: avalon-mm master tasks,
  behavioural cipher and fingerprint responders, command sequences.
  assumes the package cmd_ctrl_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_crypto_command_control;
  import cmd_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [BLOCK_W-1:0] data_in = '0;
  logic [BLOCK_W-1:0] data_out;
  logic [3:0] cipher_cmd;
  logic cipher_start;
  logic cipher_done = 1'b0;
  logic [BLOCK_W-1:0] cipher_result = '0;
  logic cipher_tag_ok = 1'b0;
  logic fp_start;
  logic fp_done = 1'b0;
  logic random_source_select;
  logic random_word_valid = 1'b0;
  logic [3:0] last_cmd = 4'h0;
  logic tag_good = 1'b1;
  logic [BLOCK_W-1:0] exp_out = '0;
  int cstarts = 0;
  int fstarts = 0;
  int cdly = 0;
  int fdly = 0;
  int err_total = 0;
  int n_checks = 0;
  int ncs;
  int nfs;

  always #12.5 mclk = ~mclk;

  crypto_command_control dut_u (
    .MCLK(mclk), .SYS_RST(sys_rst),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .DATA_IN(data_in), .DATA_OUT(data_out),
    .CIPHER_CMD(cipher_cmd), .CIPHER_START(cipher_start), .CIPHER_DONE(cipher_done),
    .CIPHER_RESULT(cipher_result), .CIPHER_TAG_OK(cipher_tag_ok),
    .FP_START(fp_start), .FP_DONE(fp_done),
    .RANDOM_SOURCE_SELECT(random_source_select), .RANDOM_WORD_VALID(random_word_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // engines answer a few cycles late, so the fsm must really wait for done
  always @(posedge mclk)
  begin
    cipher_done <= 1'b0;
    fp_done <= 1'b0;
    if (cipher_start === 1'b1)
    begin
      last_cmd <= cipher_cmd;
      cstarts <= cstarts + 1;
      cdly <= 4;
    end
    else if (cdly > 0)
    begin
      cdly <= cdly - 1;
      if (cdly == 1)
      begin
        cipher_done <= 1'b1;
        cipher_result <= {4{28'hC1F0E0D, last_cmd}};
        cipher_tag_ok <= tag_good;
      end
    end
    if (fp_start === 1'b1)
    begin
      fstarts <= fstarts + 1;
      fdly <= 6;
    end
    else if (fdly > 0)
    begin
      fdly <= fdly - 1;
      if (fdly == 1)
        fp_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is seen low; settle sampling on negedge
  task automatic xfer(input logic wr, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge mclk);
  endtask : xfer

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    wr(ADDR_OPERATION_SELECT, OP_RANDOM_RAW);
    chk(random_source_select, 1'b1);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h100);
    wr(ADDR_OPERATION_SELECT, OP_RANDOM_DECIMATED);
    chk(random_source_select, 1'b0);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    @(posedge mclk);
    random_word_valid <= 1'b1;
    @(posedge mclk);
    random_word_valid <= 1'b0;
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h80);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    nfs = fstarts;
    wr(ADDR_OPERATION_SELECT, OP_FINGERPRINT_RUN);
    chk(fstarts, nfs + 1);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    // full session: key, nonce, setup, header, seal, open, tag
    for (int c = 4; c <= 12; c++)
    begin
      @(posedge mclk);
      data_in <= {4{32'(c)}};
      wr(ADDR_OPERATION_SELECT, 32'(c));
      chk(last_cmd, c - 3);
      if (c >= 8)
        exp_out = {4{28'hC1F0E0D, 4'(c - 3)}};
      chk(data_out, exp_out);
      rd_chk(ADDR_DATA_OUT_LO, exp_out[31:0]);
      rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
      rd_chk(ADDR_DATA_IN_LO, (c >= 11) ? 32'h1 : 32'h0);
    end
    @(posedge mclk);
    tag_good <= 1'b0;
    wr(ADDR_OPERATION_SELECT, OP_OPEN_LAST_BLOCK);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    ncs = cstarts;
    nfs = fstarts;
    wr(ADDR_OPERATION_SELECT, OP_IDLE);
    wr(ADDR_OPERATION_SELECT, 32'h0000000D);
    chk(cstarts + fstarts, ncs + nfs);
    rd_chk(ADDR_OPERATION_SELECT, 32'h0000000D);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    wr(ADDR_ENGINE_ACTIVITY, 32'hFFFFFFFF);
    rd_chk(ADDR_ENGINE_ACTIVITY, 32'h0);
    rd_chk(ADDR_DATA_IN_LO, 32'h0);
    print_verdict();
  end

  // the sequence needs well under two thousand cycles
  initial
  begin
    #(25 * 20000);
    err_total++;
    print_verdict();
  end
endmodule : test_crypto_command_control
`default_nettype wire
